// ===== hdl/ptac_consts.svh
`ifndef PTAC_CONSTS_SVH
`define PTAC_CONSTS_SVH

// register byte offsets
`define PTAC_OFS_ACTION 5'h00
`define PTAC_OFS_INT_EN 5'h04
`define PTAC_OFS_FLAGS 5'h08
`define PTAC_OFS_CLEAR 5'h0C
`define PTAC_OFS_SRC_SEL 5'h10

// field positions
`define PTAC_ACT_A_LSB 0
`define PTAC_ACT_B_LSB 2
`define PTAC_FLG_INT 0
`define PTAC_FLG_CBC 1
`define PTAC_FLG_OST 2
`define PTAC_EN_CBC 1
`define PTAC_EN_OST 2
`define PTAC_SEL_CBC_LSB 0
`define PTAC_SEL_OST_LSB 8

// widths
`define PTAC_NUM_TRIP 6
`define PTAC_ADR_W 5

// reset values
`define PTAC_RST_ACTION 4'h0
`define PTAC_RST_INT_EN 2'h0
`define PTAC_RST_SEL 6'h00

`endif

// ===== hdl/ptac_pkg.sv
package ptac_pkg;

    typedef enum logic [1:0] {
        PTAC_ACT_HIZ = 2'h0,
        PTAC_ACT_HIGH = 2'h1,
        PTAC_ACT_LOW = 2'h2,
        PTAC_ACT_NONE = 2'h3
    } ptac_action_t;

    typedef logic [5:0] ptac_trip_vec_t;

endpackage

// ===== hdl/ptac_out_if.sv
`timescale 1ns/1ps
`default_nettype none

interface ptac_out_if;
    import ptac_pkg::*;
    ptac_action_t action;
    logic trip;
    logic pwm_in;
    logic pin;
    logic oe;

    modport core (output action, output trip, output pwm_in, input pin, input oe);
    modport stage (input action, input trip, input pwm_in, output pin, output oe);
endinterface

`default_nettype wire

// ===== hdl/ptac_out_stage.sv
`timescale 1ns/1ps
`default_nettype none

module ptac_out_stage (
    input wire logic clk_i,
    input wire logic rst_i,
    ptac_out_if.stage port_io
);
    import ptac_pkg::*;

    logic pin_r, pin_nxt;
    logic oe_r, oe_nxt;

    always_comb begin
        pin_nxt = port_io.pwm_in;
        oe_nxt = 1'b1;
        if (port_io.trip) begin
            unique case (port_io.action)
                PTAC_ACT_HIZ: begin
                    // pin is driven low while released
                    pin_nxt = 1'b0;
                    oe_nxt = 1'b0;
                end
                PTAC_ACT_HIGH: pin_nxt = 1'b1;
                PTAC_ACT_LOW: pin_nxt = 1'b0;
                PTAC_ACT_NONE: pin_nxt = port_io.pwm_in;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_r <= 1'b0;
            oe_r <= 1'b1;
        end else begin
            pin_r <= pin_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign port_io.pin = pin_r;
    assign port_io.oe = oe_r;
endmodule // ptac_out_stage

`default_nettype wire

// ===== hdl/ptac_top.sv
// Our own choices: the register offsets and the Wishbone interface to the registers.
`include "ptac_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module ptac_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`PTAC_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // fault inputs, active low
    input wire ptac_pkg::ptac_trip_vec_t trip_n_i,
    // time-base counter at zero
    input wire logic tb_zero_i,
    // pwm from the action stage
    input wire logic pwm_a_i,
    input wire logic pwm_b_i,
    // pwm pins
    output logic pwm_out_a_o,
    output logic pwm_out_a_oe_o,
    output logic pwm_out_b_o,
    output logic pwm_out_b_oe_o,
    // trip interrupt, one-cycle pulse
    output logic trip_interrupt_o
);
    import ptac_pkg::*;

    // byte-lane merge for a 16-bit register; upper bus lanes are ignored
    function automatic logic [15:0] lane_wr(input logic [15:0] old_v,
                                            input logic [31:0] dat,
                                            input logic [3:0] sel);
        logic [15:0] v;
        v = old_v;
        if (sel[0]) v[7:0] = dat[7:0];
        if (sel[1]) v[15:8] = dat[15:8];
        return v;
    endfunction

    // true when any asserted fault input is enabled in the given selection
    function automatic logic src_hit(input ptac_trip_vec_t act,
                                     input ptac_trip_vec_t sel);
        return |(act & sel);
    endfunction

    // bus state
    logic ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic bus_req;
    logic wr_stb;
    logic [15:0] wr_word;
    logic [15:0] flags_word;

    // configuration
    logic [3:0] action_r, action_nxt;
    logic [1:0] int_en_r, int_en_nxt;
    ptac_trip_vec_t cbc_sel_r, cbc_sel_nxt;
    ptac_trip_vec_t ost_sel_r, ost_sel_nxt;

    // trip state
    ptac_trip_vec_t flt_act;
    logic ost_hit;
    logic cbc_hit;
    logic [2:0] clr_vec;
    logic ost_flg_r, ost_flg_nxt;
    logic cbc_flg_r, cbc_flg_nxt;
    logic int_flg_r, int_flg_nxt;
    logic cbc_trip_r, cbc_trip_nxt;
    logic irq_r, irq_nxt;
    logic irq_req;
    logic trip_any;

    // output stages
    ptac_out_if if_a();
    ptac_out_if if_b();

    assign bus_req = wb_cyc_i & wb_stb_i;
    // a write lands at the edge where the master sees ack high
    assign wr_stb = bus_req & wb_we_i & ack_r;

    // ---------------- configuration registers ----------------
    always_comb begin
        wr_word = 16'h0000;
        action_nxt = action_r;
        int_en_nxt = int_en_r;
        cbc_sel_nxt = cbc_sel_r;
        ost_sel_nxt = ost_sel_r;
        if (wr_stb) begin
            unique case (wb_adr_i)
                `PTAC_OFS_ACTION: begin
                    wr_word = lane_wr({12'h000, action_r}, wb_dat_i, wb_sel_i);
                    action_nxt = wr_word[3:0];
                end
                `PTAC_OFS_INT_EN: begin
                    wr_word = lane_wr({13'h0000, int_en_r, 1'b0}, wb_dat_i, wb_sel_i);
                    int_en_nxt[1] = wr_word[`PTAC_EN_OST];
                    int_en_nxt[0] = wr_word[`PTAC_EN_CBC];
                end
                `PTAC_OFS_SRC_SEL: begin
                    wr_word = lane_wr({2'b00, ost_sel_r, 2'b00, cbc_sel_r},
                                      wb_dat_i, wb_sel_i);
                    cbc_sel_nxt = wr_word[`PTAC_SEL_CBC_LSB +: 6];
                    ost_sel_nxt = wr_word[`PTAC_SEL_OST_LSB +: 6];
                end
                default: begin
                    // flags are read-only and clear is handled below
                    wr_word = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            action_r <= `PTAC_RST_ACTION;
            int_en_r <= `PTAC_RST_INT_EN;
            cbc_sel_r <= `PTAC_RST_SEL;
            ost_sel_r <= `PTAC_RST_SEL;
        end else begin
            action_r <= action_nxt;
            int_en_r <= int_en_nxt;
            cbc_sel_r <= cbc_sel_nxt;
            ost_sel_r <= ost_sel_nxt;
        end
    end

    // ---------------- trip flags and interrupt ----------------
    always_comb begin
        flt_act = ~trip_n_i;
        ost_hit = src_hit(flt_act, ost_sel_r);
        cbc_hit = src_hit(flt_act, cbc_sel_r);
        clr_vec = 3'h0;
        if (wr_stb && (wb_adr_i == `PTAC_OFS_CLEAR) && wb_sel_i[0]) begin
            clr_vec = wb_dat_i[2:0];
        end
        // set wins over clear so a trip in the clear cycle is not lost
        ost_flg_nxt = ost_hit | (ost_flg_r & ~clr_vec[`PTAC_FLG_OST]);
        cbc_flg_nxt = cbc_hit | (cbc_flg_r & ~clr_vec[`PTAC_FLG_CBC]);
        // the pin condition ignores the flag clear and waits for zero
        cbc_trip_nxt = cbc_trip_r;
        if (cbc_hit) begin
            cbc_trip_nxt = 1'b1;
        end else if (tb_zero_i) begin
            cbc_trip_nxt = 1'b0;
        end
        irq_req = (ost_flg_r & int_en_r[1])
                | (cbc_flg_r & int_en_r[0]);
        // the latched flag blocks further pulses until software clears it
        irq_nxt = irq_req & ~int_flg_r;
        int_flg_nxt = irq_nxt | (int_flg_r & ~clr_vec[`PTAC_FLG_INT]);
        trip_any = ost_hit | ost_flg_r | cbc_hit | cbc_trip_r;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ost_flg_r <= 1'b0;
            cbc_flg_r <= 1'b0;
            int_flg_r <= 1'b0;
            cbc_trip_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            ost_flg_r <= ost_flg_nxt;
            cbc_flg_r <= cbc_flg_nxt;
            int_flg_r <= int_flg_nxt;
            cbc_trip_r <= cbc_trip_nxt;
            irq_r <= irq_nxt;
        end
    end

    // ---------------- bus read and acknowledge ----------------
    always_comb begin
        flags_word = 16'h0000;
        flags_word[`PTAC_FLG_OST] = ost_flg_r;
        flags_word[`PTAC_FLG_CBC] = cbc_flg_r;
        flags_word[`PTAC_FLG_INT] = int_flg_r;
        // one wait state: ack rises the cycle after the request
        ack_nxt = bus_req & ~ack_r;
        dat_nxt = dat_r;
        if (bus_req && !ack_r && !wb_we_i) begin
            unique case (wb_adr_i)
                `PTAC_OFS_ACTION: begin
                    dat_nxt = {28'h0000000, action_r};
                end
                `PTAC_OFS_INT_EN: begin
                    dat_nxt = {29'h00000000, int_en_r, 1'b0};
                end
                `PTAC_OFS_FLAGS: begin
                    dat_nxt = {16'h0000, flags_word};
                end
                `PTAC_OFS_SRC_SEL: begin
                    dat_nxt = {18'h00000, ost_sel_r, 2'b00, cbc_sel_r};
                end
                default: begin
                    // clear register and holes read as zero
                    dat_nxt = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h00000000;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    // ---------------- pin stages ----------------
    assign if_a.action = ptac_action_t'(action_r[`PTAC_ACT_A_LSB +: 2]);
    assign if_a.trip = trip_any;
    assign if_a.pwm_in = pwm_a_i;
    assign if_b.action = ptac_action_t'(action_r[`PTAC_ACT_B_LSB +: 2]);
    assign if_b.trip = trip_any;
    assign if_b.pwm_in = pwm_b_i;

    ptac_out_stage u_stage_a (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .port_io(if_a.stage)
    );

    ptac_out_stage u_stage_b (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .port_io(if_b.stage)
    );

    // ---------------- outputs, all from flip-flops ----------------
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign trip_interrupt_o = irq_r;
    assign pwm_out_a_o = if_a.pin;
    assign pwm_out_a_oe_o = if_a.oe;
    assign pwm_out_b_o = if_b.pin;
    assign pwm_out_b_oe_o = if_b.oe;
endmodule // ptac_top

// ===== sim/ptac_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ptac_chk(input wire logic clk_i,input wire logic rst_i,
input wire logic trip_interrupt_o,input wire logic wb_ack_o,
input wire logic wb_cyc_i,input wire logic wb_stb_i,
input wire logic pwm_out_a_o,input wire logic pwm_out_a_oe_o,
input wire logic pwm_out_b_o,input wire logic pwm_out_b_oe_o);
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
a_irq_one_pulse: assert property (trip_interrupt_o |=> !trip_interrupt_o)
else $error("irq held");
a_ack_drops: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
a_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
else $error("ack late");
a_ack_needs_req: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
else $error("ack without request");
a_hiz_a_low: assert property (!pwm_out_a_oe_o |-> !pwm_out_a_o)
else $error("released pin a driven");
a_hiz_b_low: assert property (!pwm_out_b_oe_o |-> !pwm_out_b_o)
else $error("released pin b driven");
endmodule // ptac_chk
bind ptac_top ptac_chk u_chk(.clk_i(clk_i),.rst_i(rst_i),
.trip_interrupt_o(trip_interrupt_o),.wb_ack_o(wb_ack_o),
.wb_cyc_i(wb_cyc_i),.wb_stb_i(wb_stb_i),
.pwm_out_a_o(pwm_out_a_o),.pwm_out_a_oe_o(pwm_out_a_oe_o),
.pwm_out_b_o(pwm_out_b_o),.pwm_out_b_oe_o(pwm_out_b_oe_o));
`default_nettype wire

// ===== sim/ptac_far.sv
`timescale 1ns/1ps
`default_nettype none
module ptac_far(input wire logic clk_i,input wire logic [5:0] fault_i,
output ptac_pkg::ptac_trip_vec_t trip_n_o,output logic pwm_o);
initial pwm_o=1'b0;
// pins are active low; pwm toggles so a forced level is visible
always @(posedge clk_i) begin
trip_n_o<=~fault_i;
pwm_o<=~pwm_o;
end
endmodule // ptac_far
`default_nettype wire

// ===== sim/ptac_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin n_compared++; if((a)!==(b)) begin n_errors++; \
$display("CHECK FAILED %0t %h",$time,a); end end
module ptac_top_bench;
logic clk_i=0,rst_i=1,cyc=0,we=0,tb_zero=0,pwm;
logic [4:0] adr=0;
logic [31:0] d=0,q,rd;
logic [5:0] fault=0;
logic a,aoe,b,boe,irq,ack;
ptac_pkg::ptac_trip_vec_t trip_n;
int n_errors=0,n_compared=0,n_irq=0;
always #12.5 clk_i=~clk_i;
always @(posedge clk_i) if(irq===1'b1) n_irq<=n_irq+1;
ptac_far u_far(.clk_i(clk_i),.fault_i(fault),.trip_n_o(trip_n),.pwm_o(pwm));
ptac_top u_dut(.clk_i(clk_i),.rst_i(rst_i),.wb_cyc_i(cyc),.wb_stb_i(cyc),
.wb_we_i(we),.wb_adr_i(adr),.wb_sel_i(4'hF),.wb_dat_i(d),.wb_dat_o(q),
.wb_ack_o(ack),.trip_n_i(trip_n),.tb_zero_i(tb_zero),.pwm_a_i(pwm),
.pwm_b_i(~pwm),.pwm_out_a_o(a),.pwm_out_a_oe_o(aoe),.pwm_out_b_o(b),
.pwm_out_b_oe_o(boe),.trip_interrupt_o(irq));
task automatic wb(input logic w,input logic [4:0] ad,input logic [31:0] dv);
@(posedge clk_i);
cyc<=1'b1;
we<=w;
adr<=ad;
d<=dv;
do @(posedge clk_i); while(ack!==1'b1);
rd=q;
cyc<=1'b0;
@(posedge clk_i);
endtask
task automatic finish_test;
$display("errors %0d compared %0d",n_errors,n_compared);
if(n_errors==0&&n_compared>0) $display("bench passed");
else $display("bench failed");
$finish;
endtask
initial begin
repeat(5000) @(posedge clk_i);
n_errors++;
finish_test;
end
initial begin
repeat(12) @(posedge clk_i);
rst_i<=1'b0;
wb(0,5'h08,0); `CHK(rd[2:0],3'h0)
wb(1,5'h00,32'h6); wb(0,5'h00,0); `CHK(rd[3:0],4'h6)
wb(1,5'h10,32'h200); wb(1,5'h04,32'h4);
@(posedge clk_i) fault<=6'h01;
repeat(6) @(negedge clk_i);
`CHK({aoe,boe,a^b},3'b111)
`CHK(n_irq,0)
@(posedge clk_i) fault<=6'h02;
repeat(6) @(negedge clk_i);
`CHK({a,aoe,b,boe},4'b0111)
`CHK(n_irq,1)
@(posedge clk_i) fault<=6'h00;
repeat(3) @(negedge clk_i);
`CHK({a,aoe,b,boe},4'b0111)
wb(0,5'h08,0); `CHK(rd[2:0],3'h5)
wb(1,5'h0C,32'h7); wb(0,5'h08,0); `CHK(rd[2:0],3'h0)
repeat(2) @(negedge clk_i);
`CHK({aoe,boe,a^b},3'b111)
`CHK(n_irq,1)
wb(1,5'h00,32'h0); wb(1,5'h04,32'h0); wb(1,5'h10,32'h1);
@(posedge clk_i) fault<=6'h01;
repeat(6) @(negedge clk_i);
`CHK({aoe,boe,a,b},4'b0000)
`CHK(n_irq,1)
wb(1,5'h04,32'h2); repeat(3) @(negedge clk_i); `CHK(n_irq,2)
@(posedge clk_i) fault<=6'h00;
repeat(4) @(negedge clk_i);
`CHK({aoe,boe},2'b00)
@(posedge clk_i) tb_zero<=1'b1;
@(posedge clk_i) tb_zero<=1'b0;
repeat(3) @(negedge clk_i);
`CHK({aoe,boe,a^b},3'b111)
wb(0,5'h08,0); `CHK(rd[2:0],3'h3)
wb(1,5'h0C,32'h1); repeat(3) @(negedge clk_i); `CHK(n_irq,3)
@(posedge clk_i) fault<=6'h01;
repeat(3) @(posedge clk_i);
wb(1,5'h0C,32'h2); wb(0,5'h08,0); `CHK(rd[1],1'b1)
@(posedge clk_i) fault<=6'h00;
finish_test;
end
endmodule // ptac_top_bench
`default_nettype wire
